// ===== rtl/scr_sys_ctrl.sv
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - pce2 bit zero gates second CAN clock
// - pce2 upper bits read zero, ignore writes
// - system and peripheral clocks at half master
// - run mode: core and peripheral clocks on
// - wait mode: core clocks off, peripherals on
// - unmasked interrupt wakes core from wait
// - stop exits: CAN, unclocked irq, resets
// - control register disables stop/wait, temporary or permanent
// - four reset sources, two async, two sync
// - power-on reset extended 2^21 system clocks
// - three 32-clock release windows in order
// - resets release only on rising clock edge
// - security blocks external program, debug access
// - security from two flash bytes
// - secure forces internal boot at 0x020000
// - secure ignores external boot select pin
// - JTAG TAP active at boot
// - security bytes drive core read disable
// - peripherals clocked from system clock, not core clock
// - pce1 sixteen gate bits, reset ones
module scr_sys_ctrl
  import scr_pkg::*;
#(
  parameter int          POR_EXTEND_CYCLES = POR_EXTEND_DEFAULT,
  parameter logic [15:0] SEC_ENABLE_CODE   = 16'h5a5a
)
(
  // bus clock and power-on reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // other reset sources
  input  wire logic               ext_reset_n,
  input  wire logic               watchdog_reset,
  // power mode requests and wake events
  input  wire logic               stop_request,
  input  wire logic               wait_request,
  input  wire logic               periph_irq,
  input  wire logic               unclocked_irq,
  input  wire logic               can_activity,
  // flash security and boot pins
  input  wire logic [7:0]         security_byte_lo,
  input  wire logic [7:0]         security_byte_hi,
  input  wire logic               external_boot_select,
  // clocks out
  output logic                    system_clock,
  output logic                    core_clock,
  output logic      [NPERIPH-1:0] periph_clock,
  output logic                    second_can_clock,
  // resets out
  output logic                    periph_reset_n,
  output logic                    core_reset_n,
  output logic                    core_run,
  // security and boot out
  output logic                    core_read_disable,
  output logic                    ext_prog_block,
  output logic                    debug_block,
  output logic                    jtag_tap_enable,
  output logic      [23:0]        boot_address,
  output logic      [1:0]         boot_mode,
  output logic      [1:0]         power_mode
);
  logic               rst_n;
  logic               por_pending_reg;
  logic               system_clock_reg;
  logic               tick;
  logic [NPIN-1:0]    pin_in;
  logic [NPIN-1:0]    pin_s0_reg;
  logic [NPIN-1:0]    pin_s1_reg;
  logic [NPIN-1:0]    pin_s2_reg;
  logic [NPIN-1:0]    pin_agree;
  logic [NPIN-1:0]    pin_level_reg;
  logic [NPIN-1:0]    pin_level_next;
  logic               can_prev_reg;
  logic               can_rise;
  logic               unclk_wake;
  logic               ap_valid;
  logic               ap_write;
  logic               dp_write_reg;
  logic [ADDR_W-1:0]  dp_addr_reg;
  logic               wr_ctrl;
  logic               wr_pce1;
  logic               wr_pce2;
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [CTRL_W-1:0]  ctrl_next;
  logic [15:0]        pce1_reg;
  logic [15:0]        pce1_next;
  logic               pce2_reg;
  logic               pce2_next;
  logic               swrst_reg;
  logic               sync_rst;
  logic [31:0]        rd_mux;
  logic [31:0]        status_word;
  logic [31:0]        hrdata_reg;
  logic               stop_allowed;
  logic               wait_allowed;
  scr_mode_e          mode_reg;
  scr_mode_e          mode_next;
  scr_stage_e         stage_reg;
  scr_stage_e         stage_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [CNT_W-1:0]   win_end;
  logic               win_last;
  logic               por_clear;
  logic               clocks_on;
  logic               periph_on;
  logic [15:0]        sec_code;
  logic               sec_live;
  logic               secure_reg;
  scr_boot_e          boot_reg;
  scr_boot_e          boot_next;
  logic [23:0]        boot_addr_reg;
  logic               periph_rst_n_reg;
  logic               core_rst_n_reg;
  logic               core_run_reg;

  // internal reset: ext pin and power-on assert at once
  scr_rst_sync u_rst_sync
  (
    .hclk   (hclk),
    .arst_n (hresetn & ext_reset_n),
    .rst_n  (rst_n)
  );

  // power-on flag, cleared only once the extension has run
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      por_pending_reg <= 1'b1;
    else if (por_clear)
      por_pending_reg <= 1'b0;
  end

  // master clock halved into the system clock
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      system_clock_reg <= 1'b0;
    else
      system_clock_reg <= ~system_clock_reg;
  end

  assign tick = ~system_clock_reg;

  // pin synchronisers: a change counts once stages two and three agree
  assign pin_in         = {external_boot_select, can_activity,
                           unclocked_irq};
  assign pin_agree      = ~(pin_s1_reg ^ pin_s2_reg);
  assign pin_level_next = (pin_agree & pin_s2_reg)
                        | (~pin_agree & pin_level_reg);

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s0_reg    <= '0;
      pin_s1_reg    <= '0;
      pin_s2_reg    <= '0;
      pin_level_reg <= '0;
      can_prev_reg  <= 1'b0;
    end
    else
    begin
      pin_s0_reg    <= pin_in;
      pin_s1_reg    <= pin_s0_reg;
      pin_s2_reg    <= pin_s1_reg;
      pin_level_reg <= pin_level_next;
      can_prev_reg  <= pin_level_reg[PIN_CAN];
    end
  end

  // the edge itself wakes the part, so that frame is not received
  assign can_rise   = pin_level_reg[PIN_CAN] & ~can_prev_reg;
  assign unclk_wake = pin_level_reg[PIN_UNCLK];

  // ahb-lite address and data phase
  assign ap_valid = hsel & hready & htrans[TRANS_ACT];
  assign ap_write = ap_valid & hwrite & (hsize == SIZE_WORD);

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end
    else
    begin
      dp_write_reg <= ap_write;
      dp_addr_reg  <= haddr[ADDR_W-1:0];
    end
  end

  assign wr_ctrl = dp_write_reg & (dp_addr_reg == ADDR_CTRL);
  assign wr_pce1 = dp_write_reg & (dp_addr_reg == ADDR_PCE1);
  assign wr_pce2 = dp_write_reg & (dp_addr_reg == ADDR_PCE2);

  // temporary disables follow the write, permanent ones only set
  assign ctrl_next[CTRL_STOP_TMP]  = wr_ctrl ? hwdata[CTRL_STOP_TMP]
                                             : ctrl_reg[CTRL_STOP_TMP];
  assign ctrl_next[CTRL_WAIT_TMP]  = wr_ctrl ? hwdata[CTRL_WAIT_TMP]
                                             : ctrl_reg[CTRL_WAIT_TMP];
  assign ctrl_next[CTRL_STOP_PERM] = ctrl_reg[CTRL_STOP_PERM]
                                   | (wr_ctrl & hwdata[CTRL_STOP_PERM]);
  assign ctrl_next[CTRL_WAIT_PERM] = ctrl_reg[CTRL_WAIT_PERM]
                                   | (wr_ctrl & hwdata[CTRL_WAIT_PERM]);
  assign pce1_next = wr_pce1 ? hwdata[15:0] : pce1_reg;
  assign pce2_next = wr_pce2 ? hwdata[PCE2_SECOND_CAN_CONTROLLER] : pce2_reg;

  // software and watchdog resets act on the clock
  assign sync_rst = swrst_reg | watchdog_reset;

  // permanent disables clear only on a reset
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg  <= CTRL_RESET;
      pce1_reg  <= PCE1_RESET;
      pce2_reg  <= PCE2_RESET;
      swrst_reg <= 1'b0;
    end
    else if (sync_rst)
    begin
      ctrl_reg  <= CTRL_RESET;
      pce1_reg  <= PCE1_RESET;
      pce2_reg  <= PCE2_RESET;
      swrst_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      pce1_reg  <= pce1_next;
      pce2_reg  <= pce2_next;
      swrst_reg <= wr_ctrl & hwdata[CTRL_SWRST];
    end
  end

  // read data, captured in the address phase
  assign status_word = (32'(mode_reg) << STAT_MODE_LSB)
                     | (32'(stage_reg) << STAT_STAGE_LSB)
                     | (32'(boot_reg) << STAT_BOOT_LSB)
                     | (32'(secure_reg) << STAT_SECURE)
                     | (32'(por_pending_reg) << STAT_POR);
  assign rd_mux = (haddr[ADDR_W-1:0] == ADDR_CTRL)   ? 32'(ctrl_reg)    :
                  (haddr[ADDR_W-1:0] == ADDR_PCE1)   ? 32'(pce1_reg)    :
                  (haddr[ADDR_W-1:0] == ADDR_PCE2)   ? 32'(pce2_reg)    :
                  (haddr[ADDR_W-1:0] == ADDR_STATUS) ? status_word      :
                                                       32'h0000_0000;

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_reg <= '0;
    else if (ap_valid & ~hwrite)
      hrdata_reg <= rd_mux;
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // reset release sequencer, counting system clock cycles
  assign win_end   = (stage_reg == ST_EXTEND)
                   ? CNT_W'(POR_EXTEND_CYCLES)
                   : CNT_W'(SEQ_WINDOW - 1);
  assign win_last  = tick & (cnt_reg == win_end);
  assign por_clear = (stage_reg == ST_EXTEND) & win_last;

  always_comb
  begin
    stage_next = stage_reg;
    cnt_next   = tick ? cnt_reg + CNT_W'(1) : cnt_reg;
    case (stage_reg)
      ST_EXTEND:
      begin
        if (!por_pending_reg || win_last)
        begin
          stage_next = ST_CLOCKS;
          cnt_next   = '0;
        end
      end
      ST_CLOCKS:
      begin
        if (win_last)
        begin
          stage_next = ST_PERIPH;
          cnt_next   = '0;
        end
      end
      ST_PERIPH:
      begin
        if (win_last)
        begin
          stage_next = ST_CORE;
          cnt_next   = '0;
        end
      end
      ST_CORE:
      begin
        if (win_last)
        begin
          stage_next = ST_DONE;
          cnt_next   = '0;
        end
      end
      ST_DONE:
        cnt_next = '0;
      default:
      begin
        stage_next = ST_EXTEND;
        cnt_next   = '0;
      end
    endcase
    if (sync_rst)
    begin
      stage_next = ST_CLOCKS;
      cnt_next   = '0;
    end
  end

  // outputs registered from the next stage, so they change on the same edge as the stage
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_reg        <= ST_EXTEND;
      cnt_reg          <= '0;
      periph_rst_n_reg <= 1'b0;
      core_rst_n_reg   <= 1'b0;
      core_run_reg     <= 1'b0;
    end
    else
    begin
      stage_reg        <= stage_next;
      cnt_reg          <= cnt_next;
      periph_rst_n_reg <= (stage_next == ST_PERIPH)
                        | (stage_next == ST_CORE)
                        | (stage_next == ST_DONE);
      core_rst_n_reg   <= (stage_next == ST_CORE)
                        | (stage_next == ST_DONE);
      core_run_reg     <= (stage_next == ST_DONE);
    end
  end

  assign periph_reset_n = periph_rst_n_reg;
  assign core_reset_n   = core_rst_n_reg;
  assign core_run       = core_run_reg;

  // flash security and boot mode, tracked until the core runs
  assign sec_code  = {security_byte_hi, security_byte_lo};
  assign sec_live  = (sec_code == SEC_ENABLE_CODE);
  assign boot_next = sec_live ? BOOT_SECURE :
                     pin_level_reg[PIN_BOOT] ? BOOT_EXTERNAL :
                                               BOOT_INTERNAL;

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secure_reg    <= 1'b1;
      boot_reg      <= BOOT_SECURE;
      boot_addr_reg <= BOOT_FLASH_ADDR;
    end
    else if (stage_reg != ST_DONE)
    begin
      secure_reg    <= sec_live;
      boot_reg      <= boot_next;
      boot_addr_reg <= (boot_next == BOOT_EXTERNAL) ? EXT_BOOT_ADDR
                                                    : BOOT_FLASH_ADDR;
    end
  end

  assign core_read_disable = secure_reg;
  assign ext_prog_block    = secure_reg;
  assign debug_block       = secure_reg;
  assign jtag_tap_enable   = 1'b1;
  assign boot_address      = boot_addr_reg;
  assign boot_mode         = boot_reg;

  // power modes
  assign stop_allowed = ~(ctrl_reg[CTRL_STOP_TMP]
                        | ctrl_reg[CTRL_STOP_PERM]);
  assign wait_allowed = ~(ctrl_reg[CTRL_WAIT_TMP]
                        | ctrl_reg[CTRL_WAIT_PERM]);

  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN:
      begin
        if (core_run_reg && stop_request && stop_allowed)
          mode_next = MODE_STOP;
        else if (core_run_reg && wait_request && wait_allowed)
          mode_next = MODE_WAIT;
      end
      MODE_WAIT:
      begin
        if (periph_irq || unclk_wake)
          mode_next = MODE_RUN;
      end
      MODE_STOP:
      begin
        if (can_rise || unclk_wake)
          mode_next = MODE_RUN;
      end
      default:
        mode_next = MODE_RUN;
    endcase
    if (sync_rst)
      mode_next = MODE_RUN;
  end

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= MODE_RUN;
    else
      mode_reg <= mode_next;
  end

  assign power_mode = mode_reg;

  // clock gating lanes
  assign clocks_on = (stage_reg != ST_EXTEND);
  assign periph_on = clocks_on & (mode_reg != MODE_STOP);

  scr_clk_if gif ();

  assign gif.rise                 = tick;
  assign gif.enable[NPERIPH-1:0]  = pce1_reg & {NPERIPH{periph_on}};
  assign gif.enable[GATE_SECOND_CAN_CONTROLLER]    = pce2_reg & periph_on;
  assign gif.enable[GATE_CORE]    = clocks_on & (mode_reg == MODE_RUN);

  scr_clk_gate u_clk_gate
  (
    .hclk  (hclk),
    .rst_n (rst_n),
    .gif   (gif)
  );

  assign system_clock     = system_clock_reg;
  assign periph_clock     = gif.gated[NPERIPH-1:0];
  assign second_can_clock = gif.gated[GATE_SECOND_CAN_CONTROLLER];
  assign core_clock       = gif.gated[GATE_CORE];
endmodule

// ===== shared/scr_pkg.sv
package scr_pkg;
  // bus map
  localparam int              ADDR_W      = 8;
  localparam logic [7:0]      ADDR_CTRL   = 8'h00;
  localparam logic [7:0]      ADDR_PCE1   = 8'h04;
  localparam logic [7:0]      ADDR_PCE2   = 8'h08;
  localparam logic [7:0]      ADDR_STATUS = 8'h0c;
  localparam int              TRANS_ACT   = 1;
  localparam logic [2:0]      SIZE_WORD   = 3'h2;
  // system control register fields
  localparam int              CTRL_W         = 4;
  localparam int              CTRL_STOP_TMP  = 0;
  localparam int              CTRL_WAIT_TMP  = 1;
  localparam int              CTRL_STOP_PERM = 2;
  localparam int              CTRL_WAIT_PERM = 3;
  localparam int              CTRL_SWRST     = 4;
  localparam logic [3:0]      CTRL_RESET     = 4'h0;
  // clock gate registers
  localparam int              NPERIPH    = 16;
  localparam logic [15:0]     PCE1_RESET = 16'hffff;
  localparam logic            PCE2_RESET = 1'b1;
  localparam int              PCE2_SECOND_CAN_CONTROLLER  = 0;
  localparam int              NGATE      = 18;
  localparam int              GATE_SECOND_CAN_CONTROLLER  = 16;
  localparam int              GATE_CORE  = 17;
  // status register fields
  localparam int              STAT_MODE_LSB  = 0;
  localparam int              STAT_STAGE_LSB = 4;
  localparam int              STAT_BOOT_LSB  = 8;
  localparam int              STAT_SECURE    = 12;
  localparam int              STAT_POR       = 13;
  // clocking and reset sequencing
  localparam int              MASTER_MHZ_MAX     = 120;
  localparam int              SYS_DIV            = 2;
  localparam int              SYS_MHZ_MAX        = MASTER_MHZ_MAX / SYS_DIV;
  localparam int              CNT_W              = 22;
  localparam int              SEQ_WINDOW         = 32;
  localparam int              POR_EXTEND_DEFAULT = 2 ** 21;
  localparam int              NSYNC              = 3;
  // boot
  localparam logic [23:0]     BOOT_FLASH_ADDR = 24'h020000;
  localparam logic [23:0]     EXT_BOOT_ADDR   = 24'h000000;
  // pin synchroniser slots
  localparam int              NPIN      = 3;
  localparam int              PIN_UNCLK = 0;
  localparam int              PIN_CAN   = 1;
  localparam int              PIN_BOOT  = 2;

  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} scr_mode_e;
  typedef enum logic [2:0] {ST_EXTEND, ST_CLOCKS, ST_PERIPH, ST_CORE,
                            ST_DONE} scr_stage_e;
  typedef enum logic [1:0] {BOOT_INTERNAL, BOOT_EXTERNAL,
                            BOOT_SECURE} scr_boot_e;
endpackage

// ===== shared/scr_clk_if.sv
`timescale 1ns/1ps
interface scr_clk_if import scr_pkg::*; ();
  logic             rise;
  logic [NGATE-1:0] enable;
  logic [NGATE-1:0] gated;
  modport gate (input rise, input enable, output gated);
  modport ctl  (output rise, output enable, input gated);
endinterface

// ===== rtl/scr_rst_sync.sv
`timescale 1ns/1ps
module scr_rst_sync
  import scr_pkg::*;
(
  // clock and raw reset
  input  wire logic hclk,
  input  wire logic arst_n,
  // released reset
  output logic      rst_n
);
  logic [NSYNC-1:0] chain_reg;

  // asserts at once, releases on a rising edge
  always_ff @(posedge hclk or negedge arst_n)
  begin
    if (!arst_n)
      chain_reg <= '0;
    else
      chain_reg <= {chain_reg[NSYNC-2:0], 1'b1};
  end

  assign rst_n = chain_reg[NSYNC-1];
endmodule

// ===== rtl/scr_clk_gate.sv
`timescale 1ns/1ps
module scr_clk_gate
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic rst_n,
  // gating lanes
  scr_clk_if.gate   gif
);
  logic [NGATE-1:0] clk_reg;
  logic [NGATE-1:0] clk_next;

  // each lane is a flop: enable is looked at only where the lane
  // would rise, so pulses are whole and free of glitches
  assign clk_next = gif.rise ? gif.enable : '0;

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
      clk_reg <= '0;
    else
      clk_reg <= clk_next;
  end

  assign gif.gated = clk_reg;
endmodule

// ===== test/scr_core_model.sv
`timescale 1ns/1ps
module scr_core_model
  import scr_pkg::*;
#(
  parameter logic [15:0] SEC_CODE = 16'h3c3c
)
(
  // clock and core state
  input  wire logic       hclk,
  input  wire logic       core_run,
  // bench commands
  input  wire logic       go_wait,
  input  wire logic       go_stop,
  input  wire logic       secure_sel,
  // sleep instructions and flash bytes
  output logic            stop_request,
  output logic            wait_request,
  output logic      [7:0] security_byte_lo,
  output logic      [7:0] security_byte_hi
);
  logic pll_off_reg;
  initial {stop_request, wait_request, pll_off_reg} = '0;
  // non-volatile bytes hold the secure code or its inverse
  assign {security_byte_hi, security_byte_lo} =
    secure_sel ? SEC_CODE : ~SEC_CODE;
  // pll is shut down a cycle before the stop instruction
  always @(posedge hclk)
  begin
    pll_off_reg  <= go_stop & core_run;
    stop_request <= go_stop & pll_off_reg & ~stop_request;
    wait_request <= go_wait & core_run & ~wait_request;
  end
endmodule

// ===== test/scr_sys_ctrl_props.sv
`timescale 1ns/1ps
module scr_sys_ctrl_props
  import scr_pkg::*;
(
  // clock and resets
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ext_reset_n,
  input wire logic        watchdog_reset,
  // wake events
  input wire logic        periph_irq,
  input wire logic        unclocked_irq,
  input wire logic        can_activity,
  // clocks and sequence
  input wire logic        system_clock,
  input wire logic        core_clock,
  input wire logic        second_can_clock,
  input wire logic        periph_reset_n,
  input wire logic        core_reset_n,
  input wire logic        core_run,
  input wire logic [1:0]  power_mode,
  // security and boot
  input wire logic        core_read_disable,
  input wire logic        ext_prog_block,
  input wire logic        debug_block,
  input wire logic [23:0] boot_address,
  input wire logic [1:0]  boot_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !ext_reset_n || watchdog_reset);
  AST_CAN_GATED: assert property (
    second_can_clock |-> system_clock) else $error("can clock ungated");
  AST_HALF_RATE: assert property (
    core_run && $past(core_run) |-> $changed(system_clock))
    else $error("system clock not half rate");
  AST_RUN_CLOCKS: assert property (
    (core_run && power_mode == 2'h0) [*3] |-> core_clock == system_clock)
    else $error("core clock off in run");
  AST_WAIT_CORE: assert property (
    (power_mode == 2'h1) [*3] |-> !core_clock) else $error("core clock in wait");
  AST_WAIT_WAKE: assert property (
    power_mode == 2'h1 && periph_irq |=> power_mode == 2'h0)
    else $error("no wake from wait");
  AST_STOP_STAY: assert property (
    (power_mode == 2'h2 && !can_activity && !unclocked_irq) [*5]
    |=> power_mode == 2'h2) else $error("stop left without event");
  AST_CORE_WIN: assert property (
    $rose(core_reset_n) |-> ##60 !core_run ##[1:8] core_run)
    else $error("core window length");
  AST_PERIPH_WIN: assert property (
    $rose(periph_reset_n) |-> ##60 !core_reset_n ##[1:8] core_reset_n)
    else $error("periph window length");
  AST_SECURE_BOOT: assert property (
    ext_prog_block |-> boot_mode != 2'h1 && boot_address == BOOT_FLASH_ADDR)
    else $error("secure boot not internal");
  AST_SECURE_SAME: assert property (
    core_run |-> debug_block == ext_prog_block
      && core_read_disable == debug_block) else $error("blocks disagree");
  cover property (power_mode == 2'h1 ##1 power_mode == 2'h0);
  cover property (power_mode == 2'h2 ##1 power_mode == 2'h0);
  cover property ($rose(core_run));
endmodule
bind scr_sys_ctrl scr_sys_ctrl_props scr_sys_ctrl_props_i (.*);

// ===== test/scr_sys_ctrl_test.sv
`timescale 1ns/1ps
module scr_sys_ctrl_test
  import scr_pkg::*;
();
  logic        hclk = 1'b0;
  logic        hresetn, ext_reset_n, watchdog_reset, hsel, hwrite, hready;
  logic        periph_irq, unclocked_irq, can_activity, external_boot_select;
  logic        go_wait, go_stop, secure_sel, stop_request, wait_request;
  logic        hreadyout, hresp, system_clock, core_clock, second_can_clock;
  logic        periph_reset_n, core_reset_n, core_run, core_read_disable;
  logic        ext_prog_block, debug_block, jtag_tap_enable;
  logic [1:0]  htrans, boot_mode, power_mode;
  logic [2:0]  hsize;
  logic [4:0]  act;
  logic [7:0]  security_byte_lo, security_byte_hi;
  logic [15:0] periph_clock;
  logic [23:0] boot_address;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fails, checks_done, cycles, n_core, n_can, n_per, t_mark, t_por;

  // security code value is arbitrary
  scr_sys_ctrl #(.POR_EXTEND_CYCLES(8), .SEC_ENABLE_CODE(16'h3c3c))
    scr_sys_ctrl_i (.*);
  scr_core_model #(.SEC_CODE(16'h3c3c)) scr_core_model_i (.*);
  assign hready = hreadyout;
  assign {watchdog_reset, can_activity, periph_irq, go_stop, go_wait} = act;
  always #5 hclk = ~hclk;

  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= SIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(what, e, rd);
  endtask

  task automatic hold(input int b, input int n);
    @(posedge hclk);
    act[b] <= 1'b1;
    repeat (n) @(posedge hclk);
    act[b] <= 1'b0;
  endtask

  task automatic clocks;
    {n_core, n_can, n_per} = '0;
    repeat (4) @(posedge hclk);
    repeat (16)
    begin
      @(negedge hclk);
      n_core += core_clock;
      n_can += second_can_clock;
      n_per += periph_clock[0];
    end
  endtask

  task automatic pm(input logic [1:0] e);
    @(negedge hclk);
    chk("power_mode", {30'h0, e}, {30'h0, power_mode});
  endtask

  task automatic wait_run(input logic lvl);
    int i;
    for (i = 0; i < 1000 && core_run !== lvl; i++) @(posedge hclk);
    chk("core_run", {31'h0, lvl}, {31'h0, core_run});
  endtask

  task automatic t_boot;
    wait_run(1'b1);
    t_por = cycles - t_mark;
    chk("boot_mode", 32'h0, {30'h0, boot_mode});
    chk("jtag", 32'h1, {31'h0, jtag_tap_enable});
    chk("hresp", 32'h0, {31'h0, hresp});
    rchk("pce1", ADDR_PCE1, 32'hffff);
    rchk("pce2", ADDR_PCE2, 32'h1);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    rchk("status", ADDR_STATUS, 32'h40);
    rchk("unmapped", 8'h10, 32'h0);
    $display("boot test done");
  endtask

  task automatic t_gate;
    bus(ADDR_PCE2, 1'b1, 32'hfffffffe);
    rchk("pce2 off", ADDR_PCE2, 32'h0);
    bus(ADDR_PCE1, 1'b1, 32'hfffe);
    clocks();
    chk("can clock", 32'h0, n_can);
    chk("periph clock", 32'h0, n_per);
    chk("core clock", 32'h8, n_core);
    bus(ADDR_PCE2, 1'b1, 32'h1);
    bus(ADDR_PCE1, 1'b1, 32'hffff);
    clocks();
    chk("can clock on", 32'h8, n_can);
    chk("periph clock on", 32'h8, n_per);
    $display("gate test done");
  endtask

  task automatic t_power;
    hold(0, 4);
    pm(2'h1);
    clocks();
    chk("wait core", 32'h0, n_core);
    chk("wait periph", 32'h8, n_per);
    hold(2, 1);
    pm(2'h0);
    hold(1, 4);
    pm(2'h2);
    hold(2, 2);
    repeat (6) @(posedge hclk);
    pm(2'h2);
    hold(3, 8);
    repeat (4) @(posedge hclk);
    pm(2'h0);
    hold(1, 4);
    pm(2'h2);
    @(posedge hclk);
    unclocked_irq <= 1'b1;
    repeat (8) @(posedge hclk);
    unclocked_irq <= 1'b0;
    pm(2'h0);
    $display("power test done");
  endtask

  task automatic t_disable;
    int d_sw;
    bus(ADDR_CTRL, 1'b1, 32'h6);
    hold(0, 4);
    hold(1, 4);
    pm(2'h0);
    bus(ADDR_CTRL, 1'b1, 32'h0);
    rchk("ctrl perm", ADDR_CTRL, 32'h4);
    hold(0, 4);
    pm(2'h1);
    hold(2, 1);
    bus(ADDR_CTRL, 1'b1, 32'h10);
    t_mark = cycles;
    wait_run(1'b0);
    wait_run(1'b1);
    d_sw = cycles - t_mark;
    rchk("ctrl cleared", ADDR_CTRL, 32'h0);
    hold(4, 1);
    wait_run(1'b0);
    repeat (40) @(posedge hclk);
    hold(4, 1);
    t_mark = cycles;
    wait_run(1'b1);
    t_mark = cycles - t_mark - d_sw;
    chk("restart", 32'h1, {31'h0, t_mark >= -3 && t_mark <= 3});
    $display("disable test done");
  endtask

  task automatic t_secure;
    int s;
    for (s = 1; s >= 0; s--)
    begin
      @(posedge hclk);
      secure_sel <= s[0];
      external_boot_select <= 1'b1;
      ext_reset_n <= 1'b0;
      repeat (3) @(posedge hclk);
      ext_reset_n <= 1'b1;
      t_mark = cycles;
      wait_run(1'b1);
      chk("boot_mode", s ? 32'h2 : 32'h1,
          {30'h0, boot_mode});
      chk("boot_address", {8'h0, s ? BOOT_FLASH_ADDR : EXT_BOOT_ADDR},
          {8'h0, boot_address});
      chk("blocks", s ? 32'h7 : 32'h0, {29'h0, core_read_disable,
          ext_prog_block, debug_block});
    end
    chk("por extension", 32'h10, t_por - (cycles - t_mark));
    $display("secure test done");
  endtask

  initial
  begin
    {hresetn, ext_reset_n, hsel, hwrite, unclocked_irq} = 5'b01000;
    {htrans, hsize, haddr, hwdata, act, secure_sel} = '0;
    external_boot_select = 1'b0;
    {fails, checks_done, cycles} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_mark = cycles;
    t_boot();
    t_gate();
    t_power();
    t_disable();
    t_secure();
    conclude();
  end
endmodule
